// *** hdl/alu_pkg.sv ***
// shared constants and types for the byte/word arithmetic-logic unit
package alu_pkg;
   localparam int DATA_W = 8; // byte width
   localparam int REG_COUNT = 32; // general-purpose registers
   localparam int IDX_W = 5; // register index width
   localparam int IMM_W = 6; // word immediate width
   localparam int ONE_CYCLES = 1; // single-cycle operations
   localparam int WORD_CYCLES = 2; // word operations
   // flag bit positions in the status byte
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam logic [7:0] FLAGS_RESET = 8'h00; // status reset value
   localparam logic [7:0] ALL_ONES = 8'hff; // inversion base
   // operation codes
   typedef enum logic [3:0] {
      OP_SUM = 4'h0, OP_SUM_CARRY = 4'h1, OP_WORD_SUM = 4'h2, OP_DIFF = 4'h3,
      OP_DIFF_IMM = 4'h4, OP_BORROW_DIFF = 4'h5, OP_BORROW_DIFF_IMM = 4'h6,
      OP_WORD_DIFF = 4'h7, OP_MASK = 4'h8, OP_MASK_IMM = 4'h9, OP_MERGE = 4'ha,
      OP_MERGE_IMM = 4'hb, OP_XMERGE = 4'hc, OP_INVERT = 4'hd
   } op_e;
endpackage

// *** hdl/byte_flag_calc.sv ***
// combinational byte adder/subtracter and logic unit with flag generation
`timescale 1ns/1ns
module byte_flag_calc
   import alu_pkg::*;
(
   input wire logic [7:0] opA,
   input wire logic [7:0] opB,
   input wire logic carryIn,
   input wire logic subtract,
   input wire logic useCarry,
   input wire logic [1:0] logicSel,
   input wire logic isLogic,
   output logic [7:0] result,
   output logic carryOut,
   output logic halfOut,
   output logic ovfOut
);
   logic [8:0] wide; // 9-bit sum or difference
   logic cin; // effective carry or borrow
   // arithmetic path and flags for carry, half-carry and overflow
   always_comb
   begin
      cin = useCarry & carryIn;
      if (subtract)
         wide = {1'b0, opA} - {1'b0, opB} - {8'h00, cin};
      else
         wide = {1'b0, opA} + {1'b0, opB} + {8'h00, cin};
      result = wide[7:0];
      carryOut = wide[8];
      ovfOut = 1'b0;
      if (subtract)
      begin
         // borrow from bit three, signed overflow of a difference
         halfOut = (~opA[3] & opB[3]) | (opB[3] & result[3]) | (result[3] & ~opA[3]);
         ovfOut = (opA[7] & ~opB[7] & ~result[7]) | (~opA[7] & opB[7] & result[7]);
      end
      else
      begin
         // carry from bit three, signed overflow of a sum
         halfOut = (opA[3] & opB[3]) | (opB[3] & ~result[3]) | (~result[3] & opA[3]);
         ovfOut = (opA[7] & opB[7] & ~result[7]) | (~opA[7] & ~opB[7] & result[7]);
      end
      if (isLogic)
      begin
         // logic results clear overflow
         case (logicSel)
            2'd0: result = opA & opB;
            2'd1: result = opA | opB;
            2'd2: result = opA ^ opB;
            default: result = ALL_ONES - opA;
         endcase
         ovfOut = 1'b0;
         carryOut = 1'b1;
      end
   end
endmodule

// *** hdl/byte_word_arith_logic_unit.sv ***
// arithmetic-logic datapath with register file, status flags and word sequencing
`timescale 1ns/1ns
module byte_word_arith_logic_unit
   import alu_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic opValid,
   input wire alu_pkg::op_e opCode,
   input wire logic [alu_pkg::IDX_W-1:0] destIdx,
   input wire logic [alu_pkg::IDX_W-1:0] source_reg,
   input wire logic [7:0] immValue,
   input wire logic [alu_pkg::IDX_W-1:0] readIdx,
   output logic [7:0] readData,
   output logic [7:0] statusFlags,
   output logic busy,
   output logic opDone
);
   import alu_pkg::*;
   // sequencer states
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_HIGH = 2'b10} state_e;
   // all state of the unit
   typedef struct packed {
      logic [REG_COUNT-1:0][7:0] regs; // register file
      logic [7:0] flags; // status byte
      state_e state; // sequencer
      logic [IDX_W-1:0] pairIdx; // low index of pair in flight
      logic wordSub; // word op is a difference
      logic [7:0] lowRes; // low byte result for flags
      logic lowCarry; // carry out of low byte
      logic [7:0] rdData; // read port
      logic busyF; // word op running
      logic doneF; // completion pulse
   } state_s;
   state_s st_q, st_d;
   logic [7:0] aOp, bOp; // operands to calculator
   logic cIn, sub, useC, isLog; // calculator controls
   logic [1:0] lSel; // logic select
   logic [7:0] res; // calculator result
   logic cOut, hOut, vOut; // calculator flags
   byte_flag_calc calcInst (
      .opA(aOp), .opB(bOp), .carryIn(cIn), .subtract(sub), .useCarry(useC),
      .logicSel(lSel), .isLogic(isLog), .result(res), .carryOut(cOut),
      .halfOut(hOut), .ovfOut(vOut)
   );
   // next state: operand select, write-back and flag update
   always_comb
   begin
      st_d = st_q;
      st_d.doneF = 1'b0;
      aOp = st_q.regs[destIdx];
      bOp = st_q.regs[source_reg];
      cIn = st_q.flags[FLAG_C];
      sub = 1'b0;
      useC = 1'b0;
      isLog = 1'b0;
      lSel = 2'd0;
      case (st_q.state)
         ST_IDLE:
         begin
            if (opValid)
            begin
               case (opCode)
                  OP_SUM: sub = 1'b0;
                  OP_SUM_CARRY: useC = 1'b1;
                  OP_DIFF: sub = 1'b1;
                  OP_BORROW_DIFF:
                  begin
                     sub = 1'b1;
                     useC = 1'b1;
                  end
                  OP_DIFF_IMM:
                  begin
                     sub = 1'b1;
                     bOp = immValue;
                  end
                  OP_BORROW_DIFF_IMM:
                  begin
                     sub = 1'b1;
                     useC = 1'b1;
                     bOp = immValue;
                  end
                  OP_WORD_SUM, OP_WORD_DIFF:
                  begin
                     // low byte first, immediate is unsigned six bits
                     sub = (opCode == OP_WORD_DIFF);
                     bOp = {2'b00, immValue[IMM_W-1:0]};
                  end
                  OP_MASK: isLog = 1'b1;
                  OP_MASK_IMM:
                  begin
                     isLog = 1'b1;
                     bOp = immValue;
                  end
                  OP_MERGE:
                  begin
                     isLog = 1'b1;
                     lSel = 2'd1;
                  end
                  OP_MERGE_IMM:
                  begin
                     isLog = 1'b1;
                     lSel = 2'd1;
                     bOp = immValue;
                  end
                  OP_XMERGE:
                  begin
                     isLog = 1'b1;
                     lSel = 2'd2;
                  end
                  OP_INVERT:
                  begin
                     isLog = 1'b1;
                     lSel = 2'd3;
                  end
                  default: sub = 1'b0;
               endcase
               st_d.regs[destIdx] = res;
               if (opCode == OP_WORD_SUM || opCode == OP_WORD_DIFF)
               begin
                  // hold flags until the high byte completes
                  st_d.state = ST_HIGH;
                  st_d.pairIdx = destIdx;
                  st_d.wordSub = (opCode == OP_WORD_DIFF);
                  st_d.lowRes = res;
                  st_d.lowCarry = cOut;
                  st_d.busyF = 1'b1;
               end
               else
               begin
                  // byte flags; borrow chains keep zero only if already set
                  st_d.doneF = 1'b1;
                  st_d.flags[FLAG_Z] = (res == 8'h00) &
                     (((opCode == OP_BORROW_DIFF) || (opCode == OP_BORROW_DIFF_IMM)) ? st_q.flags[FLAG_Z] : 1'b1);
                  st_d.flags[FLAG_N] = res[7];
                  st_d.flags[FLAG_V] = vOut;
                  st_d.flags[FLAG_S] = res[7] ^ vOut;
                  if (!isLog)
                  begin
                     st_d.flags[FLAG_C] = cOut;
                     st_d.flags[FLAG_H] = hOut;
                  end
                  else if (opCode == OP_INVERT)
                     st_d.flags[FLAG_C] = 1'b1;
               end
            end
         end
         ST_HIGH:
         begin
            // second cycle: high byte with carry or borrow from low byte
            aOp = st_q.regs[st_q.pairIdx + 5'd1];
            bOp = 8'h00;
            sub = st_q.wordSub;
            useC = 1'b1;
            cIn = st_q.lowCarry;
            st_d.regs[st_q.pairIdx + 5'd1] = res;
            st_d.flags[FLAG_Z] = ({res, st_q.lowRes} == 16'h0000);
            st_d.flags[FLAG_N] = res[7];
            st_d.flags[FLAG_C] = cOut;
            // difference overflows when the high bit falls, sum when it rises
            st_d.flags[FLAG_V] = st_q.wordSub ? (aOp[7] & ~res[7]) : (~aOp[7] & res[7]);
            st_d.flags[FLAG_S] = res[7] ^ (st_q.wordSub ? (aOp[7] & ~res[7]) : (~aOp[7] & res[7]));
            st_d.state = ST_IDLE;
            st_d.busyF = 1'b0;
            st_d.doneF = 1'b1;
         end
         default: st_d.state = ST_IDLE;
      endcase
      st_d.rdData = st_d.regs[readIdx];
   end
   // single register of all state
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st_q <= '0;
         st_q.flags <= FLAGS_RESET;
         st_q.state <= ST_IDLE;
      end
      else
         st_q <= st_d;
   end
   assign readData = st_q.rdData;
   assign statusFlags = st_q.flags;
   assign busy = st_q.busyF;
   assign opDone = st_q.doneF;
   // byte op finishes next edge
   sequence byteIssue;
      opValid && st_q.state == ST_IDLE && opCode != OP_WORD_SUM && opCode != OP_WORD_DIFF;
   endsequence
   sequence wordIssue;
      opValid && st_q.state == ST_IDLE && (opCode == OP_WORD_SUM || opCode == OP_WORD_DIFF);
   endsequence
   byte_one_cycle_a: assert property (@(posedge clk) disable iff (sys_rst) byteIssue |=> opDone && !busy)
      else $error("byte op not done in one cycle");
   word_two_cycle_a: assert property (@(posedge clk) disable iff (sys_rst) wordIssue |=> busy && !opDone ##1 opDone && !busy)
      else $error("word op not done in two cycles");
   invert_carry_a: assert property (@(posedge clk) disable iff (sys_rst)
      opValid && st_q.state == ST_IDLE && opCode == OP_INVERT |=> statusFlags[FLAG_C])
      else $error("inversion did not set carry");
   logic_vclear_a: assert property (@(posedge clk) disable iff (sys_rst)
      opValid && st_q.state == ST_IDLE && opCode >= OP_MASK |=> !statusFlags[FLAG_V])
      else $error("logic op left overflow set");
   logic_keeps_h_a: assert property (@(posedge clk) disable iff (sys_rst)
      opValid && st_q.state == ST_IDLE && opCode >= OP_MASK && opCode != OP_INVERT
      |=> statusFlags[FLAG_C] == $past(statusFlags[FLAG_C]) && statusFlags[FLAG_H] == $past(statusFlags[FLAG_H]))
      else $error("logic op changed carry or half-carry");
   sign_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
      opDone |-> statusFlags[FLAG_S] == (statusFlags[FLAG_N] ^ statusFlags[FLAG_V]))
      else $error("sign flag not N xor V");
   diff_imm_a: assert property (@(posedge clk) disable iff (sys_rst)
      opValid && st_q.state == ST_IDLE && opCode == OP_DIFF_IMM && destIdx == readIdx
      |=> readData == 8'($past(st_q.regs[destIdx]) - $past(immValue)))
      else $error("immediate difference wrong");
   diff_carry_a: assert property (@(posedge clk) disable iff (sys_rst)
      opValid && st_q.state == ST_IDLE && opCode == OP_DIFF
      |=> statusFlags[FLAG_C] == ($past(st_q.regs[destIdx]) < $past(st_q.regs[source_reg])))
      else $error("difference borrow wrong");
   borrow_imm_a: assert property (@(posedge clk) disable iff (sys_rst)
      opValid && st_q.state == ST_IDLE && opCode == OP_BORROW_DIFF_IMM && !st_q.flags[FLAG_Z]
      |=> !statusFlags[FLAG_Z])
      else $error("borrow chain set zero");
   word_diff_a: assert property (@(posedge clk) disable iff (sys_rst)
      opValid && st_q.state == ST_IDLE && opCode == OP_WORD_DIFF && immValue[IMM_W-1:0] == 6'h00
      |=> ##1 !statusFlags[FLAG_C])
      else $error("zero word difference borrowed");
endmodule

// *** tb/tb_byte_word_arith_logic_unit.sv ***
// self-checking bench for the byte/word arithmetic-logic unit
`timescale 1ns/1ns
`define CHK(g, e) \
begin \
   checked++; \
   if ((g) !== (e)) \
   begin \
      num_errors++; \
      $display("wrong value at %0t: got %h expected %h", $time, g, e); \
   end \
end
module tb_byte_word_arith_logic_unit;
   import alu_pkg::*;
   logic clk, sys_rst, opValid; // clock, reset, request
   op_e opCode; // operation
   logic [4:0] destIdx, sourceReg, readIdx; // indices
   logic [7:0] immValue, readData, statusFlags; // data
   logic busy, opDone; // sequencing outputs
   logic [7:0] m [32]; // model registers
   logic [7:0] f; // model flags
   int num_errors = 0;
   int checked = 0;

   byte_word_arith_logic_unit dut_u (.clk(clk), .sys_rst(sys_rst), .opValid(opValid), .opCode(opCode),
      .destIdx(destIdx), .source_reg(sourceReg), .immValue(immValue), .readIdx(readIdx),
      .readData(readData), .statusFlags(statusFlags), .busy(busy), .opDone(opDone));

   // 40 ns clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // model one op, issue it, then judge result, flags and cycle count
   task automatic run(input op_e op, input logic [4:0] d, input logic [4:0] s, input logic [7:0] k);
      logic [7:0] a, b, r;
      logic [8:0] t;
      logic [4:0] ht;
      logic [15:0] w, rw;
      logic c, h, v, z, ng, cin, wd;
      int n;
      a = m[d];
      wd = op inside {OP_WORD_SUM, OP_WORD_DIFF};
      b = (op inside {OP_DIFF_IMM, OP_BORROW_DIFF_IMM, OP_MASK_IMM, OP_MERGE_IMM}) ? k : m[s];
      cin = f[0] & (op inside {OP_SUM_CARRY, OP_BORROW_DIFF, OP_BORROW_DIFF_IMM});
      c = f[0];
      h = f[5];
      v = 1'b0;
      w = {m[5'(d + 1)], a};
      rw = 16'h0000;
      r = a;
      t = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      ht = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
      // result and carry-type flags per operation
      case (op)
         OP_SUM, OP_SUM_CARRY:
         begin
            t = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            ht = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            v = (a[7] == b[7]) && (t[7] != a[7]);
            {c, r, h} = {t, ht[4]};
         end
         OP_DIFF, OP_DIFF_IMM, OP_BORROW_DIFF, OP_BORROW_DIFF_IMM:
         begin
            v = (a[7] != b[7]) && (t[7] != a[7]);
            {c, r, h} = {t, ht[4]};
         end
         OP_MASK, OP_MASK_IMM: r = a & b;
         OP_MERGE, OP_MERGE_IMM: r = a | b;
         OP_XMERGE: r = a ^ b;
         OP_INVERT: {c, r} = {1'b1, ALL_ONES - a};
         OP_WORD_SUM:
         begin
            rw = w + {10'h000, k[5:0]};
            {v, c} = {~w[15] & rw[15], w[15] & ~rw[15]};
         end
         default:
         begin
            rw = w - {10'h000, k[5:0]};
            {v, c} = {w[15] & ~rw[15], ~w[15] & rw[15]};
         end
      endcase
      // zero and sign flags; borrow ops only keep zero
      if (wd)
         {r, z, ng} = {rw[7:0], rw == 16'h0000, rw[15]};
      else
         {z, ng} = {(r == 8'h00) && (f[1] || !(op inside {OP_BORROW_DIFF, OP_BORROW_DIFF_IMM})), r[7]};
      f = {2'b00, h, ng ^ v, v, ng, z, c};
      m[d] = r;
      if (wd)
         m[5'(d + 1)] = rw[15:8];
      @(posedge clk);
      opValid <= 1'b1;
      opCode <= op;
      destIdx <= d;
      sourceReg <= s;
      immValue <= k;
      readIdx <= d;
      @(posedge clk);
      // during a word op a stray request is held up and must be ignored
      if (wd)
         opCode <= OP_INVERT;
      else
         opValid <= 1'b0;
      n = 1;
      #1;
      if (wd)
         `CHK(busy, 1'b1)
      while (opDone !== 1'b1 && n < 5)
      begin
         @(posedge clk);
         opValid <= 1'b0;
         n++;
         #1;
      end
      `CHK(n, wd ? WORD_CYCLES : ONE_CYCLES)
      `CHK(readData, r)
      `CHK(statusFlags, f)
      // high byte of the pair
      if (wd)
      begin
         @(posedge clk);
         readIdx <= 5'(d + 1);
         @(posedge clk);
         #1;
         `CHK(readData, rw[15:8])
      end
   endtask

   // put a byte into a register via clear then merge
   task automatic load(input logic [4:0] d, input logic [7:0] k);
      run(OP_MASK_IMM, d, 5'h00, 8'h00);
      run(OP_MERGE_IMM, d, 5'h00, k);
   endtask

   // byte add: half carry, overflow, zero with carry, carry in
   task automatic test_add();
      load(3, 8'h0f);
      load(4, 8'h01);
      run(OP_SUM, 3, 4, 8'h00);
      load(3, 8'h7f);
      run(OP_SUM, 3, 4, 8'h00);
      load(3, 8'hff);
      run(OP_SUM, 3, 4, 8'h00);
      load(5, 8'h10);
      run(OP_SUM_CARRY, 5, 4, 8'h00);
      $display("test_add done");
   endtask

   // logic ops keep carry and half carry; invert forces carry
   task automatic test_logic();
      load(1, 8'hc3);
      load(2, 8'h5a);
      run(OP_MASK, 1, 2, 8'h00);
      run(OP_MERGE, 1, 2, 8'h00);
      run(OP_XMERGE, 1, 2, 8'h00);
      run(OP_MERGE_IMM, 1, 0, 8'h80);
      run(OP_INVERT, 1, 0, 8'h00);
      run(OP_XMERGE, 2, 2, 8'h00);
      $display("test_logic done");
   endtask

   // subtract forms, borrow and zero chaining
   task automatic test_sub();
      load(6, 8'h10);
      load(7, 8'h01);
      run(OP_DIFF, 6, 7, 8'h00);
      run(OP_DIFF_IMM, 6, 0, 8'h20);
      run(OP_BORROW_DIFF, 6, 7, 8'h00);
      load(6, 8'h01);
      run(OP_DIFF_IMM, 6, 0, 8'h01);
      run(OP_BORROW_DIFF_IMM, 6, 0, 8'h00);
      run(OP_BORROW_DIFF_IMM, 6, 0, 8'h01);
      run(OP_BORROW_DIFF, 9, 9, 8'h00);
      load(10, 8'h81);
      run(OP_BORROW_DIFF_IMM, 10, 0, 8'h80);
      $display("test_sub done");
   endtask

   // word ops: byte carry, signed overflow, borrow, pair wrap
   task automatic test_word();
      load(24, 8'hff);
      run(OP_WORD_SUM, 24, 0, 8'hff);
      load(26, 8'hff);
      load(27, 8'h7f);
      run(OP_WORD_SUM, 26, 0, 8'h01);
      run(OP_WORD_DIFF, 26, 0, 8'h01);
      run(OP_WORD_DIFF, 28, 0, 8'h3f);
      load(31, 8'h01);
      load(0, 8'h00);
      run(OP_WORD_DIFF, 31, 0, 8'h01);
      $display("test_word done");
   endtask

   // mid-run reset clears registers, flags and sequencing outputs
   task automatic test_reset();
      load(8, 8'h5a);
      @(posedge clk);
      sys_rst <= 1'b1;
      readIdx <= 5'h08;
      @(posedge clk);
      @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      `CHK(readData, 8'h00)
      `CHK(statusFlags, FLAGS_RESET)
      `CHK({busy, opDone}, 2'b00)
      f = FLAGS_RESET;
      foreach (m[i])
         m[i] = 8'h00;
      run(OP_SUM_CARRY, 8, 8, 8'h00);
      $display("test_reset done");
   endtask

   // counts and verdict
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // main sequence
   initial
   begin
      sys_rst = 1'b1;
      opValid = 1'b0;
      opCode = OP_SUM;
      destIdx = 5'h00;
      sourceReg = 5'h00;
      immValue = 8'h00;
      readIdx = 5'h00;
      f = FLAGS_RESET;
      foreach (m[i])
         m[i] = 8'h00;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      test_add();
      test_logic();
      test_sub();
      test_word();
      test_reset();
      wrap_up();
   end

   // watchdog, far beyond the roughly 130 cycles needed
   initial
   begin
      repeat (5000) @(posedge clk);
      num_errors++;
      wrap_up();
   end
endmodule
